// ---- test/mbri_host_model.sv ----
module mbri_host_model (
	input wire ref_clk,
	input wire slow,
	input wire [7:0] txByte,
	input wire txValid,
	input wire txLast,
	output logic rxValid,
	output logic [7:0] rxByte,
	output logic rxEnd,
	output logic txReady
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] rsp[$];
	initial begin
		rxValid = 1'b0;
		rxByte = 8'h00;
		rxEnd = 1'b0;
		txReady = 1'b1;
	end
	// Sink takes every byte, or every other cycle when stalling
	always @(posedge ref_clk) begin
		txReady <= slow ? !txReady : 1'b1;
	end
	// Sends one request whole, then collects the answer up to its last byte
	task automatic send(input logic [7:0] q[$]);
		int n = 0;
		rsp = {};
		foreach (q[i]) begin
			@(posedge ref_clk);
			rxValid <= 1'b1;
			rxByte <= q[i];
			rxEnd <= (i == q.size() - 1);
		end
		@(posedge ref_clk);
		rxValid <= 1'b0;
		rxEnd <= 1'b0;
		rxByte <= ~q[q.size() - 1]; // Released line shows the inverse
		while (n < 300) begin
			@(posedge ref_clk);
			n++;
			if (txValid && txReady) begin
				rsp.push_back(txByte);
				if (txLast) break;
			end
		end
	endtask
endmodule // mbri_host_model

// ---- test/mbri_register_interface_asserts.sv ----
module mbri_register_interface_asserts #(
	parameter RX_DEPTH = 32,
	parameter SPLIT_WORD = 2
) (
	input wire ref_clk,
	input wire reset_n,
	input wire clkEn,
	input wire rxValid,
	input wire [7:0] rxByte,
	input wire rxEnd,
	input wire [7:0] txByte,
	input wire txValid,
	input wire txLast,
	input wire txReady,
	input wire [159:0] inImage,
	input wire cfgAccept,
	input wire [159:0] outImage,
	input wire motorPower,
	input wire moveEnable,
	input wire configValid,
	input wire signed [31:0] joinedValue
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// Answer timing, mode gating and two-word value join
	// ----------------------------------------
	default clocking cbMain @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	sequence s_frame_end;
		clkEn && rxValid && rxEnd && !txValid;
	endsequence
	sequence s_run_two;
		clkEn [*2];
	endsequence
	sequence s_byte_taken;
		txValid && txReady && clkEn;
	endsequence
	a_answer_delay: assert property (s_frame_end ##1 s_run_two |->
		!txValid ##1 txValid) else $error("answer start late or early");
	a_answer_hold: assert property (txValid && !(txReady && clkEn) |=>
		txValid && $stable(txByte) && $stable(txLast))
		else $error("answer byte not held");
	a_last_drop: assert property (s_byte_taken ##0 txLast |=> !txValid)
		else $error("valid stays after last byte");
	a_last_valid: assert property (txLast |-> txValid)
		else $error("last flag without valid");
	a_cfg_set: assert property (clkEn && cfgAccept && outImage[15]
		|=> configValid) else $error("configuration not accepted");
	a_cfg_mode_bit: assert property (!configValid && !outImage[15]
		|=> !configValid) else $error("accepted outside config mode");
	a_cfg_sticky: assert property (configValid |=> configValid)
		else $error("configuration flag cleared");
	a_power_lag: assert property ($past(clkEn) |->
		motorPower == $past(configValid)) else $error("motor power wrong");
	a_move_gate: assert property (moveEnable |-> configValid)
		else $error("moves allowed unconfigured");
	a_move_mode: assert property (configValid && outImage[15] [*2]
		|-> !moveEnable) else $error("moves allowed in config mode");
	a_split_join: assert property ($past(clkEn) && $stable(outImage)
		|-> joinedValue == $signed(outImage[SPLIT_WORD*16 +: 16]) * 1000
		+ $signed(outImage[SPLIT_WORD*16+16 +: 16]))
		else $error("joined value wrong");
endmodule // mbri_register_interface_asserts

bind mbri_register_interface mbri_register_interface_asserts #(
	.RX_DEPTH(RX_DEPTH),
	.SPLIT_WORD(SPLIT_WORD)
) chk (.ref_clk(ref_clk), .reset_n(reset_n), .clkEn(clkEn),
	.rxValid(rxValid), .rxByte(rxByte), .rxEnd(rxEnd), .txByte(txByte),
	.txValid(txValid), .txLast(txLast), .txReady(txReady),
	.inImage(inImage), .cfgAccept(cfgAccept), .outImage(outImage),
	.motorPower(motorPower), .moveEnable(moveEnable),
	.configValid(configValid), .joinedValue(joinedValue));

// ---- test/tb.sv ----
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk, reset_n, clkEn, cfgAccept, slow;
	logic [159:0] inImage;
	wire rxValid, rxEnd, txValid, txLast, txReady;
	wire motorPower, moveEnable, configValid;
	wire [7:0] rxByte, txByte;
	wire [159:0] outImage;
	wire signed [31:0] joinedValue;
	int num_errors, samples_checked, cycles;
	logic [47:0] bad[10] = '{48'h07_0000_0001_01, 48'h2B_0000_0001_01,
		48'h03_000A_0001_02, 48'h04_0400_0001_02, 48'h02_00A0_0001_02,
		48'h02_009F_0002_02, 48'h01_40A0_0001_02, 48'h06_0009_0000_02,
		48'h05_4000_1234_03, 48'h03_0400_0000_03};
	mbri_register_interface DUT (.ref_clk(ref_clk), .reset_n(reset_n),
		.clkEn(clkEn), .rxValid(rxValid), .rxByte(rxByte), .rxEnd(rxEnd),
		.txByte(txByte), .txValid(txValid), .txLast(txLast),
		.txReady(txReady), .inImage(inImage), .cfgAccept(cfgAccept),
		.outImage(outImage), .motorPower(motorPower),
		.moveEnable(moveEnable), .configValid(configValid),
		.joinedValue(joinedValue));
	mbri_host_model host (.ref_clk(ref_clk), .slow(slow), .txByte(txByte),
		.txValid(txValid), .txLast(txLast), .rxValid(rxValid),
		.rxByte(rxByte), .rxEnd(rxEnd), .txReady(txReady));
	// ----------------------------------------
	// Clock, timeout and shared tasks
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			end_of_test();
		end
	end
	task check(string name, logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task xact(input logic [7:0] q[$], input logic [7:0] e[$]);
		host.send(q);
		check("answer length", host.rsp.size(), e.size());
		foreach (e[i]) check("answer byte", host.rsp[i], e[i]);
	endtask
	task end_of_test;
		$display("Checks %0d, mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_power_up;
		xact({8'h04, 8'h00, 8'h00, 8'h00, 8'h01},
			{8'h04, 8'h02, 8'h64, 8'h08});
		cfgAccept <= 1'b1;
		repeat (3) @(posedge ref_clk);
		cfgAccept <= 1'b0;
		check("configValid", configValid, 0);
		check("motorPower", motorPower, 0);
		check("moveEnable", moveEnable, 0);
		$display("Test power_up done");
	endtask
	task t_exceptions;
		logic [7:0] q[$];
		foreach (bad[i]) xact({bad[i][47:40], bad[i][39:32], bad[i][31:24],
			bad[i][23:16], bad[i][15:8]}, {bad[i][47:40] | 8'h80,
			bad[i][7:0]});
		// Request longer than the receive store
		q = {};
		repeat (33) q.push_back(8'h03);
		xact(q, {8'h83, 8'h03});
		$display("Test exceptions done");
	endtask
	task t_data_paths;
		slow <= 1'b1;
		xact({8'h06, 8'h04, 8'h01, 8'hA5, 8'h5A},
			{8'h06, 8'h04, 8'h01, 8'hA5, 8'h5A});
		check("out word 1", outImage[31:16], 16'hA55A);
		xact({8'h05, 8'h40, 8'h10, 8'hFF, 8'h00},
			{8'h05, 8'h40, 8'h10, 8'hFF, 8'h00});
		xact({8'h16, 8'h04, 8'h01, 8'h00, 8'hFF, 8'h12, 8'h00},
			{8'h16, 8'h04, 8'h01, 8'h00, 8'hFF, 8'h12, 8'h00});
		xact({8'h03, 8'h04, 8'h01, 8'h00, 8'h01},
			{8'h03, 8'h02, 8'h12, 8'h5B});
		xact({8'h01, 8'h40, 8'h10, 8'h00, 8'h08},
			{8'h01, 8'h01, 8'h5B});
		xact({8'h0F, 8'h40, 8'h20, 8'h00, 8'h03, 8'h01, 8'h05},
			{8'h0F, 8'h40, 8'h20, 8'h00, 8'h03});
		check("out coils", outImage[34:32], 3'b101);
		xact({8'h02, 8'h00, 8'h00, 8'h00, 8'h08},
			{8'h02, 8'h01, 8'h08});
		xact({8'h03, 8'h00, 8'h00, 8'h00, 8'h01},
			{8'h03, 8'h02, 8'h64, 8'h08});
		slow <= 1'b0;
		$display("Test data_paths done");
	endtask
	task t_split;
		xact({8'h10, 8'h04, 8'h02, 8'h00, 8'h02, 8'h04, 8'hE2, 8'h1A, 8'hFE,
			8'hBF}, {8'h10, 8'h04, 8'h02, 8'h00, 8'h02});
		check("joined negative", joinedValue, -32'sd7654321);
		xact({8'h10, 8'h04, 8'h02, 8'h00, 8'h02, 8'h04, 8'h00, 8'h0C, 8'h01,
			8'h59}, {8'h10, 8'h04, 8'h02, 8'h00, 8'h02});
		check("joined positive", joinedValue, 32'd12345);
		$display("Test split done");
	endtask
	task t_config;
		xact({8'h17, 8'h00, 8'h00, 8'h00, 8'h01, 8'h04, 8'h00, 8'h00,
			8'h01, 8'h02, 8'h80, 8'h00},
			{8'h17, 8'h02, 8'h64, 8'h08});
		check("mode bit", outImage[15], 1);
		// Acceptance must wait while the clock enable is low
		clkEn <= 1'b0;
		cfgAccept <= 1'b1;
		repeat (2) @(posedge ref_clk);
		check("frozen configValid", configValid, 0);
		clkEn <= 1'b1;
		@(posedge ref_clk);
		cfgAccept <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check("configValid", configValid, 1);
		check("motorPower", motorPower, 1);
		check("moveEnable", moveEnable, 0);
		xact({8'h06, 8'h04, 8'h00, 8'h00, 8'h00},
			{8'h06, 8'h04, 8'h00, 8'h00, 8'h00});
		check("moveEnable", moveEnable, 1);
		xact({8'h04, 8'h00, 8'h00, 8'h00, 8'h01},
			{8'h04, 8'h02, 8'h12, 8'h34});
		$display("Test config done");
	endtask
	// Main sequence
	initial begin
		reset_n = 1'b0;
		clkEn = 1'b1;
		cfgAccept = 1'b0;
		slow = 1'b0;
		inImage = {144'h0, 16'h1234};
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_power_up();
		t_exceptions();
		t_data_paths();
		t_split();
		t_config();
		end_of_test();
	end
endmodule // tb

// ---- verilog/mbri_defines.vh ----
`ifndef MBRI_DEFINES_VH
`define MBRI_DEFINES_VH

// ---------------------------------------------------------------
// Image layout
// ---------------------------------------------------------------
`define MBRI_WORDS 10
`define MBRI_IMG_BITS 160
`define MBRI_COIL_BASE 16'h4000
`define MBRI_COIL_LAST 16'h409F
`define MBRI_DI_LAST 16'h009F
`define MBRI_OUT_BASE 16'h0400
`define MBRI_OUT_LAST 16'h0409
`define MBRI_IN_LAST 16'h0009
`define MBRI_MODE_BIT 15
`define MBRI_CFG_ERR 16'h6408
`define MBRI_SPLIT_SCALE 32'h000003E8

// ---------------------------------------------------------------
// Function and exception codes
// ---------------------------------------------------------------
`define MBRI_FC_RD_COILS 8'h01
`define MBRI_FC_RD_DISC 8'h02
`define MBRI_FC_RD_HOLD 8'h03
`define MBRI_FC_RD_INPUT 8'h04
`define MBRI_FC_WR_COIL 8'h05
`define MBRI_FC_WR_REG 8'h06
`define MBRI_FC_WR_COILS 8'h0F
`define MBRI_FC_WR_REGS 8'h10
`define MBRI_FC_MASK_WR 8'h16
`define MBRI_FC_RD_WR 8'h17
`define MBRI_EXC_FLAG 8'h80
`define MBRI_EXC_NONE 8'h00
`define MBRI_EXC_FUNC 8'h01
`define MBRI_EXC_ADDR 8'h02
`define MBRI_EXC_VALUE 8'h03

// ---------------------------------------------------------------
// Quantity limits
// ---------------------------------------------------------------
`define MBRI_MAX_RD_BITS 16'h07D0
`define MBRI_MAX_WR_BITS 16'h07B0
`define MBRI_MAX_RD_REGS 16'h007D
`define MBRI_MAX_WR_REGS 16'h007B
`define MBRI_MAX_RW_WREGS 16'h0079
`define MBRI_COIL_ON 16'hFF00

`endif

// ---- verilog/mbri_register_interface.v ----
`include "mbri_defines.vh"

module mbri_register_interface #(
	parameter RX_DEPTH = 32,
	parameter SPLIT_WORD = 2
) (
	input wire ref_clk,
	input wire reset_n,
	input wire clkEn,
	input wire rxValid,
	input wire [7:0] rxByte,
	input wire rxEnd,
	output reg [7:0] txByte,
	output reg txValid,
	output reg txLast,
	input wire txReady,
	input wire [159:0] inImage,
	input wire cfgAccept,
	output reg [159:0] outImage,
	output reg motorPower,
	output reg moveEnable,
	output reg configValid,
	output reg signed [31:0] joinedValue
);

	// ---------------------------------------------------------------
	// States and write kinds
	// ---------------------------------------------------------------
	localparam S_RECV = 2'b00;
	localparam S_EXEC = 2'b01;
	localparam S_SEND = 2'b10;
	localparam WK_NONE = 3'b000;
	localparam WK_COIL1 = 3'b001;
	localparam WK_BITS = 3'b010;
	localparam WK_WORDS = 3'b011;
	localparam WK_MASK = 3'b100;

	reg [7:0] rxMem [0:RX_DEPTH-1];
	reg [5:0] rxCount;
	reg rxOvf;
	reg [1:0] state;
	reg [159:0] inBuf;
	reg [7:0] excReg;
	reg echoReg;
	reg rdOutReg;
	reg rdWordsReg;
	reg [7:0] rdBaseReg;
	reg [7:0] rdBitsReg;
	reg [4:0] txLen;
	reg [4:0] txIdx;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Big-endian 16-bit field from two request bytes
	function [15:0] field16;
		input [7:0] hi;
		input [7:0] lo;
		begin
			field16 = {hi, lo};
		end
	endfunction

	// Whole span a .. a+q-1 lies within lo .. hi
	function inSpan;
		input [15:0] a;
		input [15:0] q;
		input [15:0] lo;
		input [15:0] hi;
		reg [16:0] last;
		begin
			last = {1'b0, a} + {1'b0, q} - 17'h00001;
			inSpan = (q != 16'h0000) && (a >= lo) && (last <= {1'b0, hi});
		end
	endfunction

	// Quantity lies in 1 .. max
	function qtyOk;
		input [15:0] q;
		input [15:0] max;
		begin
			qtyOk = (q != 16'h0000) && (q <= max);
		end
	endfunction

	// ---------------------------------------------------------------
	// Request fields
	// ---------------------------------------------------------------
	wire [7:0] fc = rxMem[0];
	wire [15:0] addrA = field16(rxMem[1], rxMem[2]);
	wire [15:0] qtyA = field16(rxMem[3], rxMem[4]);
	wire [15:0] addrB = field16(rxMem[5], rxMem[6]);
	wire [15:0] qtyB = field16(rxMem[7], rxMem[8]);
	wire [7:0] bcA = rxMem[5];
	wire [7:0] bcB = rxMem[9];
	wire [15:0] rxLen = {10'h000, rxCount};
	wire [15:0] coilBytes = (qtyA + 16'h0007) >> 3;

	// ---------------------------------------------------------------
	// Request check and decode
	// ---------------------------------------------------------------
	reg [7:0] exc;
	reg echo;
	reg rdOut;
	reg rdWords;
	reg [15:0] rdBase;
	reg [15:0] rdBits;
	reg [2:0] wKind;
	reg [15:0] wStart;
	reg [15:0] wBits;
	reg [5:0] dOff;
	reg [4:0] len;
	always @* begin
		exc = `MBRI_EXC_NONE;
		echo = 1'b0;
		rdOut = 1'b0;
		rdWords = 1'b0;
		rdBase = 16'h0000;
		rdBits = 16'h0000;
		wKind = WK_NONE;
		wStart = 16'h0000;
		wBits = 16'h0000;
		dOff = 6'h03;
		len = 5'h02;
		case (fc)
		`MBRI_FC_RD_COILS, `MBRI_FC_RD_DISC: begin
			rdOut = (fc == `MBRI_FC_RD_COILS);
			rdBits = qtyA;
			if (rxOvf || rxLen < 16'h0005 ||
					!qtyOk(qtyA, `MBRI_MAX_RD_BITS))
				exc = `MBRI_EXC_VALUE;
			else if (rdOut && inSpan(addrA, qtyA, `MBRI_COIL_BASE,
					`MBRI_COIL_LAST))
				rdBase = addrA - `MBRI_COIL_BASE;
			else if (!rdOut && inSpan(addrA, qtyA, 16'h0000,
					`MBRI_DI_LAST))
				rdBase = addrA;
			else
				exc = `MBRI_EXC_ADDR;
		end
		`MBRI_FC_RD_HOLD, `MBRI_FC_RD_INPUT, `MBRI_FC_RD_WR: begin
			rdWords = 1'b1;
			if (fc == `MBRI_FC_RD_WR) begin
				rdBits = {qtyA[11:0], 4'h0};
				wKind = WK_WORDS;
				wStart = {addrB[11:0], 4'h0} - (`MBRI_OUT_BASE << 4);
				wBits = {qtyB[11:0], 4'h0};
				dOff = 6'h0A;
				if (rxOvf || !qtyOk(qtyA, `MBRI_MAX_RD_REGS) ||
						!qtyOk(qtyB, `MBRI_MAX_RW_WREGS) ||
						{8'h00, bcB} != {qtyB[14:0], 1'b0} ||
						rxLen < {8'h00, bcB} + 16'h000A)
					exc = `MBRI_EXC_VALUE;
				else if (!inSpan(addrB, qtyB, `MBRI_OUT_BASE,
						`MBRI_OUT_LAST))
					exc = `MBRI_EXC_ADDR;
			end else begin
				rdBits = {qtyA[11:0], 4'h0};
				if (rxOvf || rxLen < 16'h0005 ||
						!qtyOk(qtyA, `MBRI_MAX_RD_REGS))
					exc = `MBRI_EXC_VALUE;
			end
			if (exc == `MBRI_EXC_NONE) begin
				if (fc != `MBRI_FC_RD_INPUT && inSpan(addrA, qtyA,
						`MBRI_OUT_BASE, `MBRI_OUT_LAST)) begin
					rdOut = 1'b1;
					rdBase = {addrA[11:0], 4'h0} -
						(`MBRI_OUT_BASE << 4);
				end else if (inSpan(addrA, qtyA, 16'h0000,
						`MBRI_IN_LAST))
					rdBase = {addrA[11:0], 4'h0};
				else
					exc = `MBRI_EXC_ADDR;
			end
		end
		`MBRI_FC_WR_COIL, `MBRI_FC_WR_REG: begin
			echo = 1'b1;
			len = 5'h05;
			if (rxOvf || rxLen < 16'h0005 || (fc == `MBRI_FC_WR_COIL &&
					qtyA != `MBRI_COIL_ON && qtyA != 16'h0000))
				exc = `MBRI_EXC_VALUE;
			else if (fc == `MBRI_FC_WR_COIL) begin
				if (inSpan(addrA, 16'h0001, `MBRI_COIL_BASE,
						`MBRI_COIL_LAST)) begin
					wKind = WK_COIL1;
					wStart = addrA - `MBRI_COIL_BASE;
				end else
					exc = `MBRI_EXC_ADDR;
			end else if (inSpan(addrA, 16'h0001, `MBRI_OUT_BASE,
					`MBRI_OUT_LAST)) begin
				wKind = WK_WORDS;
				wStart = {addrA[11:0], 4'h0} - (`MBRI_OUT_BASE << 4);
				wBits = 16'h0010;
			end else
				exc = `MBRI_EXC_ADDR;
		end
		`MBRI_FC_WR_COILS, `MBRI_FC_WR_REGS: begin
			echo = 1'b1;
			len = 5'h05;
			dOff = 6'h06;
			if (rxOvf || rxLen < {8'h00, bcA} + 16'h0006 ||
					(fc == `MBRI_FC_WR_COILS &&
					(!qtyOk(qtyA, `MBRI_MAX_WR_BITS) ||
					{8'h00, bcA} != coilBytes)) ||
					(fc == `MBRI_FC_WR_REGS &&
					(!qtyOk(qtyA, `MBRI_MAX_WR_REGS) ||
					{8'h00, bcA} != {qtyA[14:0], 1'b0})))
				exc = `MBRI_EXC_VALUE;
			else if (fc == `MBRI_FC_WR_COILS) begin
				if (inSpan(addrA, qtyA, `MBRI_COIL_BASE,
						`MBRI_COIL_LAST)) begin
					wKind = WK_BITS;
					wStart = addrA - `MBRI_COIL_BASE;
					wBits = qtyA;
				end else
					exc = `MBRI_EXC_ADDR;
			end else if (inSpan(addrA, qtyA, `MBRI_OUT_BASE,
					`MBRI_OUT_LAST)) begin
				wKind = WK_WORDS;
				wStart = {addrA[11:0], 4'h0} - (`MBRI_OUT_BASE << 4);
				wBits = {qtyA[11:0], 4'h0};
			end else
				exc = `MBRI_EXC_ADDR;
		end
		`MBRI_FC_MASK_WR: begin
			echo = 1'b1;
			len = 5'h07;
			if (rxOvf || rxLen < 16'h0007)
				exc = `MBRI_EXC_VALUE;
			else if (inSpan(addrA, 16'h0001, `MBRI_OUT_BASE,
					`MBRI_OUT_LAST)) begin
				wKind = WK_MASK;
				wStart = {addrA[11:0], 4'h0} - (`MBRI_OUT_BASE << 4);
				wBits = 16'h0010;
			end else
				exc = `MBRI_EXC_ADDR;
		end
		default: exc = `MBRI_EXC_FUNC;
		endcase
		if (exc != `MBRI_EXC_NONE) begin
			wKind = WK_NONE;
			echo = 1'b0;
			len = 5'h02;
		end else if (!echo)
			len = 5'h02 + rdBits[7:3] + {4'h0, rdBits[2:0] != 3'h0};
	end

	// ---------------------------------------------------------------
	// Next output image for the accepted write
	// ---------------------------------------------------------------
	reg [159:0] next_outImg;
	integer n;
	integer off;
	integer idx;
	always @* begin
		next_outImg = outImage;
		off = 0;
		idx = 0;
		for (n = 0; n < `MBRI_IMG_BITS; n = n + 1) begin
			off = n - wStart;
			if (off >= 0 && off < wBits) begin
				case (wKind)
				WK_BITS: begin
					idx = dOff + off / 8;
					next_outImg[n] = rxMem[idx[4:0]][off % 8];
				end
				WK_WORDS: begin
					idx = dOff + 2 * (off / 16) + ((off % 16) < 8);
					next_outImg[n] = rxMem[idx[4:0]][off % 8];
				end
				WK_MASK: begin
					idx = off % 16;
					next_outImg[n] = (outImage[n] & qtyA[idx[3:0]]) |
						(addrB[idx[3:0]] & ~qtyA[idx[3:0]]);
				end
				default: next_outImg[n] = outImage[n];
				endcase
			end else if (wKind == WK_COIL1 && off == 0)
				next_outImg[n] = (qtyA == `MBRI_COIL_ON);
		end
	end

	// ---------------------------------------------------------------
	// Answer byte at the current send position
	// ---------------------------------------------------------------
	reg [7:0] next_txByte;
	reg [159:0] rdSrc;
	reg [7:0] ofs;
	reg [7:0] pos;
	integer b;
	always @* begin
		next_txByte = 8'h00;
		rdSrc = rdOutReg ? outImage : inBuf;
		ofs = 8'h00;
		pos = 8'h00;
		b = 0;
		if (excReg != `MBRI_EXC_NONE)
			next_txByte = (txIdx == 5'h00) ? (rxMem[0] | `MBRI_EXC_FLAG) :
				excReg;
		else if (echoReg)
			next_txByte = rxMem[txIdx];
		else if (txIdx == 5'h00)
			next_txByte = rxMem[0];
		else if (txIdx == 5'h01)
			next_txByte = {3'h0, txLen - 5'h02};
		else begin
			ofs = {3'h0, txIdx - 5'h02};
			if (rdWordsReg)
				ofs = {ofs[4:1], 4'h0} + (ofs[0] ? 8'h00 : 8'h08);
			else
				ofs = {ofs[4:0], 3'h0};
			for (b = 0; b < 8; b = b + 1) begin
				pos = ofs + b[7:0];
				if (pos < rdBitsReg)
					next_txByte[b] = rdSrc[rdBaseReg + pos];
			end
		end
	end

	// ---------------------------------------------------------------
	// Frame receive, execute and answer sequence
	// ---------------------------------------------------------------
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= S_RECV;
			rxCount <= 6'h00;
			rxOvf <= 1'b0;
			outImage <= 160'h0;
			inBuf <= 160'h0;
			excReg <= 8'h00;
			echoReg <= 1'b0;
			rdOutReg <= 1'b0;
			rdWordsReg <= 1'b0;
			rdBaseReg <= 8'h00;
			rdBitsReg <= 8'h00;
			txLen <= 5'h00;
			txIdx <= 5'h00;
			txByte <= 8'h00;
			txValid <= 1'b0;
			txLast <= 1'b0;
		end else if (clkEn) begin
			case (state)
			S_RECV: begin
				if (rxValid) begin
					if (rxCount < RX_DEPTH) begin
						rxMem[rxCount[4:0]] <= rxByte;
						rxCount <= rxCount + 6'h01;
					end else
						rxOvf <= 1'b1;
					if (rxEnd)
						state <= S_EXEC;
				end else if (rxCount == 6'h00) begin
					// Snapshot frozen for the whole frame
					inBuf <= inImage;
					if (!configValid)
						inBuf[15:0] <= `MBRI_CFG_ERR;
				end
			end
			S_EXEC: begin
				outImage <= next_outImg;
				excReg <= exc;
				echoReg <= echo;
				rdOutReg <= rdOut;
				rdWordsReg <= rdWords;
				rdBaseReg <= rdBase[7:0];
				rdBitsReg <= rdBits[7:0];
				txLen <= len;
				txIdx <= 5'h00;
				rxCount <= 6'h00;
				rxOvf <= 1'b0;
				state <= S_SEND;
			end
			S_SEND: begin
				if (txValid && txReady && txLast) begin
					txValid <= 1'b0;
					txLast <= 1'b0;
					state <= S_RECV;
				end else if (!txValid || txReady) begin
					txByte <= next_txByte;
					txValid <= 1'b1;
					txLast <= (txIdx == txLen - 5'h01);
					txIdx <= txIdx + 5'h01;
				end
			end
			default: state <= S_RECV;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Configuration gating of motor power and moves
	// ---------------------------------------------------------------
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			configValid <= 1'b0;
			motorPower <= 1'b0;
			moveEnable <= 1'b0;
		end else if (clkEn) begin
			if (cfgAccept && outImage[`MBRI_MODE_BIT])
				configValid <= 1'b1;
			motorPower <= configValid;
			// Command operation once configured and while the mode bit is clear
			moveEnable <= configValid &&
				!outImage[`MBRI_MODE_BIT];
		end
	end

	// ---------------------------------------------------------------
	// Join of a two-word value: upper times 1000 plus lower
	// ---------------------------------------------------------------
	wire signed [31:0] upperExt =
		{{16{outImage[SPLIT_WORD*16+15]}}, outImage[SPLIT_WORD*16 +: 16]};
	wire signed [31:0] lowerExt = {{16{outImage[SPLIT_WORD*16+31]}},
		outImage[SPLIT_WORD*16+16 +: 16]};
	wire signed [63:0] scaled = upperExt * $signed(`MBRI_SPLIT_SCALE);
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			joinedValue <= 32'h00000000;
		else if (clkEn)
			joinedValue <= scaled[31:0] + lowerExt;
	end

endmodule // mbri_register_interface
